// ===== hw/fcns_pkg.sv
// constants for the flash command next-state block
// assumes nothing beyond a systemverilog compiler
package fcns_pkg;
   // opcodes of the first transition sheet
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
   localparam logic [7:0] OP_READ_DATA    = 8'h03;
   localparam logic [7:0] OP_WRITE_DIS    = 8'h04;
   localparam logic [7:0] OP_READ_STATUS  = 8'h05;
   localparam logic [7:0] OP_WRITE_EN     = 8'h06;
   localparam logic [7:0] OP_FAST_READ    = 8'h0B;
   localparam logic [7:0] OP_CLEAR_FAIL   = 8'h30;
   localparam logic [7:0] OP_PARAM_ERASE  = 8'h40;
   // apb register byte offsets
   localparam logic [11:0] ADDR_CTRL      = 12'h000;
   localparam logic [11:0] ADDR_STATUS    = 12'h004;
   localparam logic [11:0] ADDR_LAST      = 12'h008;
   localparam logic [11:0] ADDR_FAST_ADR  = 12'h00C;
   // control register field positions
   localparam int CTRL_SW_PROT     = 0;
   localparam int CTRL_ADDR_PROT   = 1;
   localparam int CTRL_PARAM_VALID = 2;
   localparam int CTRL_DEEP_SLEEP  = 3;
   localparam int CTRL_DONE        = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // fast read framing
   localparam int FAST_ADDR_BYTES  = 3;
   localparam int FAST_DUMMY_BYTES = 1;
   typedef enum logic [1:0] {
      FCNS_READY = 2'b00,
      FCNS_BUSY  = 2'b01,
      FCNS_SLEEP = 2'b11
   } fcns_state_t;
endpackage

// ===== hw/fcns_shift.sv
// spi byte receiver for the flash command block
// assumes sclk and chip select are raw pins, mode 0, sampled by pclk
`timescale 1ns/10ps
module fcns_shift
   import fcns_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       spi_sclk,
   input  wire logic       spi_cs_n,
   input  wire logic       spi_mosi,
   output logic            byte_valid,
   output logic [7:0]      byte_data,
   output logic            frame_start,
   output logic            frame_end
);
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic       sclk_old;
      logic       cs_old;
      logic [2:0] bitcnt;
      logic [7:0] sh;
      logic [7:0] data;
      logic       valid;
   } fcns_shift_st_t;
   fcns_shift_st_t st_q, st_d;
   // s2 bits: 2 sclk, 1 cs_n, 0 mosi
   always_comb begin
      st_d       = st_q;
      st_d.s1    = {spi_sclk, spi_cs_n, spi_mosi};
      st_d.s2    = st_q.s1;
      st_d.sclk_old = st_q.s2[2];
      st_d.cs_old   = st_q.s2[1];
      st_d.valid = 1'b0;
      if (st_q.s2[1]) begin
         st_d.bitcnt = 3'd0;
      end else if (st_q.s2[2] && !st_q.sclk_old) begin
         st_d.sh     = {st_q.sh[6:0], st_q.s2[0]};
         st_d.bitcnt = st_q.bitcnt + 3'd1;
         if (st_q.bitcnt == 3'd7) begin
            st_d.data  = {st_q.sh[6:0], st_q.s2[0]};
            st_d.valid = 1'b1;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '{s1: 3'b010, s2: 3'b010, cs_old: 1'b1, default: '0};
      end else begin
         st_q <= st_d;
      end
   end
   assign byte_valid  = st_q.valid;
   assign byte_data   = st_q.data;
   assign frame_start = st_q.cs_old && !st_q.s2[1];
   assign frame_end   = !st_q.cs_old && st_q.s2[1];
endmodule

// ===== hw/fcns_top.sv
// flash command next-state logic with apb control and status
// assumes an spi host on the pins and apb software setting protection
// assumes the spi pins are asynchronous to pclk and are resynchronised inside
// What this block does
// - status write with latch set updates status, clears latch, only when software protected
// - page program: protected address keeps ready and latch; else busy
// - parameter erase: protected valid block keeps ready and latch; else busy
// - latch clear: status write, program and erase are ignored
// - deep power-down ignores every opcode here, latch unchanged
// - while busy only status read is recognised
// - fast read takes three address bytes msb first, one dummy byte
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module fcns_top
   import fcns_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        spi_sclk,
   input  wire logic        spi_cs_n,
   input  wire logic        spi_mosi,
   output logic             read_active,
   output logic             status_out_active,
   output logic             start_write,
   output logic             status_write
);
   logic       byte_valid;
   logic [7:0] byte_data;
   logic       frame_start;
   logic       frame_end;

   fcns_shift u_shift (
      .pclk        (pclk),
      .presetn     (presetn),
      .spi_sclk    (spi_sclk),
      .spi_cs_n    (spi_cs_n),
      .spi_mosi    (spi_mosi),
      .byte_valid  (byte_valid),
      .byte_data   (byte_data),
      .frame_start (frame_start),
      .frame_end   (frame_end)
   );

   typedef struct packed {
      fcns_state_t state;
      logic        write_latch_flag;
      logic [31:0] ctrl;
      logic [7:0]  opcode;
      logic        have_op;
      logic [3:0]  bytes;
      logic        op_ready;
      logic [23:0] fast_adr;
      logic [7:0]  last_op;
      logic        rd;
      logic        srd;
      logic        go;
      logic        srw;
      logic [31:0] rdata;
   } fcns_st_t;
   fcns_st_t st_q, st_d;

   // opcodes that alter the array or status
   function automatic logic is_modify(input logic [7:0] op);
      return op == OP_STATUS_WRITE || op == OP_PAGE_PROGRAM || op == OP_PARAM_ERASE;
   endfunction

   // only the defined control bits are stored; the rest read back as zero
   function automatic logic [31:0] ctrl_bits(input logic [31:0] w);
      logic [31:0] m;
      m                   = 32'h0000_0000;
      m[CTRL_SW_PROT]     = w[CTRL_SW_PROT];
      m[CTRL_ADDR_PROT]   = w[CTRL_ADDR_PROT];
      m[CTRL_PARAM_VALID] = w[CTRL_PARAM_VALID];
      m[CTRL_DEEP_SLEEP]  = w[CTRL_DEEP_SLEEP];
      m[CTRL_DONE]        = w[CTRL_DONE];
      return m;
   endfunction

   logic        acc;
   logic        setup;
   logic [31:0] rd_mux;
   assign acc   = psel && penable;
   // pready is tied high, so read data is caught in setup and stands at the access edge
   assign setup = psel && !penable;

   always_comb begin
      if (paddr == ADDR_CTRL) begin
         rd_mux = st_q.ctrl;
      end else if (paddr == ADDR_STATUS) begin
         rd_mux = {28'h000_0000, st_q.write_latch_flag, 1'b0, st_q.state};
      end else if (paddr == ADDR_LAST) begin
         rd_mux = {24'h00_0000, st_q.last_op};
      end else if (paddr == ADDR_FAST_ADR) begin
         rd_mux = {8'h00, st_q.fast_adr};
      end else begin
         rd_mux = 32'h0000_0000;
      end
   end

   always_comb begin
      st_d = st_q;
      st_d.go  = 1'b0;
      st_d.srw = 1'b0;
      if (acc && pwrite && paddr == ADDR_CTRL) begin
         st_d.ctrl = ctrl_bits(pwdata);
      end
      if (setup && !pwrite) begin
         st_d.rdata = rd_mux;
      end
      // software-driven power states
      if (st_q.ctrl[CTRL_DEEP_SLEEP] && st_q.state == FCNS_READY) begin
         st_d.state = FCNS_SLEEP;
      end else if (!st_q.ctrl[CTRL_DEEP_SLEEP] && st_q.state == FCNS_SLEEP) begin
         st_d.state = FCNS_READY;
      end
      if (st_q.ctrl[CTRL_DONE] && st_q.state == FCNS_BUSY) begin
         st_d.state = FCNS_READY;
         st_d.write_latch_flag = 1'b0;
         st_d.ctrl[CTRL_DONE] = 1'b0;
      end
      // done with no job running is dropped; left set it would end the next job at once
      if (st_q.ctrl[CTRL_DONE] && st_q.state != FCNS_BUSY) begin
         st_d.ctrl[CTRL_DONE] = 1'b0;
      end
      if (frame_start) begin
         st_d.have_op  = 1'b0;
         st_d.bytes    = 4'd0;
         st_d.op_ready = 1'b0;
      end
      if (byte_valid) begin
         if (!st_q.have_op) begin
            st_d.opcode  = byte_data;
            st_d.have_op = 1'b1;
            st_d.last_op = byte_data;
            // state is judged when the opcode lands; a job ending mid-frame unlocks nothing
            st_d.op_ready = (st_q.state == FCNS_READY);
            // output phases start right after opcode
            if (st_q.state == FCNS_READY && byte_data == OP_READ_DATA) begin
               st_d.rd = 1'b1;
            end
            if (st_q.state != FCNS_SLEEP && byte_data == OP_READ_STATUS) begin
               st_d.srd = 1'b1;
            end
         end else if (st_q.bytes != 4'hF) begin
            st_d.bytes = st_q.bytes + 4'd1;
            if (st_q.opcode == OP_FAST_READ && st_q.op_ready && st_q.state == FCNS_READY) begin
               if (st_q.bytes < 4'(FAST_ADDR_BYTES)) begin
                  st_d.fast_adr = {st_q.fast_adr[15:0], byte_data};
               end
               if (st_q.bytes == 4'(FAST_ADDR_BYTES + FAST_DUMMY_BYTES - 1)) begin
                  st_d.rd = 1'b1;
               end
            end
         end
      end
      if (frame_end) begin
         st_d.rd  = 1'b0;
         st_d.srd = 1'b0;
         // commands take effect on select rise
         if (st_q.have_op && st_q.op_ready && st_q.state == FCNS_READY) begin
            if (!st_q.write_latch_flag) begin
               if (st_q.opcode == OP_WRITE_EN) begin
                  st_d.write_latch_flag = 1'b1;
               end
               // modifying commands dropped here
            end else begin
               case (st_q.opcode)
                  OP_STATUS_WRITE: begin
                     if (st_q.ctrl[CTRL_SW_PROT]) begin
                        st_d.srw = 1'b1;
                        st_d.write_latch_flag = 1'b0;
                     end
                  end
                  OP_PAGE_PROGRAM: begin
                     if (!st_q.ctrl[CTRL_ADDR_PROT]) begin
                        // latch is left as is once a job starts; its end clears it
                        st_d.state = FCNS_BUSY;
                        st_d.go    = 1'b1;
                     end
                  end
                  OP_PARAM_ERASE: begin
                     if (!(st_q.ctrl[CTRL_ADDR_PROT] && st_q.ctrl[CTRL_PARAM_VALID])) begin
                        st_d.state = FCNS_BUSY;
                        st_d.go    = 1'b1;
                     end
                  end
                  OP_WRITE_DIS: st_d.write_latch_flag = 1'b0;
                  default: ;
               endcase
            end
            if (is_modify(st_q.opcode) && !st_q.write_latch_flag) begin
               st_d.go = 1'b0;
            end
         end
         st_d.have_op = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '{state: FCNS_READY, ctrl: CTRL_RESET, default: '0};
      end else begin
         st_q <= st_d;
      end
   end

   assign prdata            = st_q.rdata;
   assign pready            = 1'b1;
   assign pslverr           = 1'b0;
   assign read_active       = st_q.rd;
   assign status_out_active = st_q.srd;
   assign start_write       = st_q.go;
   assign status_write      = st_q.srw;
endmodule

// ===== testbench/fcns_monitor.sv
// port checker for the flash command next-state block
// assumes a bind onto fcns_top and the single pclk domain
`timescale 1ns/10ps
module fcns_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic spi_cs_n,
   input wire logic read_active,
   input wire logic status_out_active,
   input wire logic start_write,
   input wire logic status_write
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_start_one_cycle: assert property (start_write |=> !start_write)
      else $error("start pulse too long");
   a_swr_one_cycle: assert property (status_write |=> !status_write)
      else $error("status write pulse too long");
   a_start_at_deselect: assert property (start_write |-> spi_cs_n)
      else $error("write started inside a frame");
   a_swr_at_deselect: assert property (status_write |-> spi_cs_n)
      else $error("status write inside a frame");
   a_single_effect: assert property (!(start_write && status_write))
      else $error("two effects from one command");
   a_outputs_exclusive: assert property (!(read_active && status_out_active))
      else $error("read and status output together");
   a_read_ends: assert property ($rose(spi_cs_n) |-> ##[0:8] !read_active)
      else $error("read output outlives frame");
   a_status_ends: assert property ($rose(spi_cs_n) |-> ##[0:8] !status_out_active)
      else $error("status output outlives frame");
   a_read_in_frame: assert property ($rose(read_active) |-> !spi_cs_n)
      else $error("read output outside a frame");
   c_start: cover property (start_write);
   c_swr: cover property (status_write);
   c_read: cover property ($rose(read_active));
   c_status: cover property ($rose(status_out_active));
endmodule
bind fcns_top fcns_monitor u_mon (.pclk, .presetn, .spi_cs_n, .read_active,
   .status_out_active, .start_write, .status_write);

// ===== testbench/fcns_spi_host.sv
// spi host model, mode 0, clock idle low between frames
// assumes the bench calls frame; 320 ns link clock, free phase
`timescale 1ns/10ps
module fcns_spi_host (
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_mosi
);
   initial begin
      spi_sclk = 0;
      spi_cs_n = 1;
      spi_mosi = 0;
   end
   task automatic frame(input logic [7:0] q[$]);
      #7 spi_cs_n = 0;
      #160;
      foreach (q[i]) for (int b = 7; b >= 0; b--) begin
         spi_mosi = q[i][b];
         #160 spi_sclk = 1;
         #160 spi_sclk = 0;
      end
      // hold select so the sampled clock sees the last edge
      #320 spi_cs_n = 1;
      spi_mosi = ~spi_mosi;
      #640;
   endtask
endmodule

// ===== testbench/fcns_top_tb.sv
// self-checking bench for the flash command next-state block
// assumes an spi host model and apb software on the control word
`timescale 1ns/10ps
module fcns_top_tb;
   import fcns_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic        pready, pslverr, spi_sclk, spi_cs_n, spi_mosi;
   logic        read_active, status_out_active, start_write, status_write;
   logic        saw_rd = 0, saw_st = 0, err = 0;
   int          n_errors = 0, checked = 0, n_start = 0, n_swr = 0;
   always #20 pclk = ~pclk;
   fcns_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .spi_sclk, .spi_cs_n, .spi_mosi, .read_active,
      .status_out_active, .start_write, .status_write);
   fcns_spi_host host (.spi_sclk, .spi_cs_n, .spi_mosi);
   always @(posedge pclk) begin
      if (start_write === 1'b1) n_start++;
      if (status_write === 1'b1) n_swr++;
      if (read_active === 1'b1) saw_rd = 1;
      if (status_out_active === 1'b1) saw_st = 1;
   end
   task chk(input string what, input logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // only the watchdog ends a wait for pready
      do @(posedge pclk); while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
   endtask
   // prdata is caught in the setup cycle, so one read carries current data
   task rdc(input logic [11:0] a, input logic [31:0] m, e, input string what);
      apb(0, a, 32'h0000_0000);
      chk(what, e, rd & m);
      chk("pslverr", 32'h0000_0000, 32'(err));
   endtask
   task st(input logic [31:0] m, e);
      rdc(ADDR_STATUS, m, e, "status");
   endtask
   task fr(input logic [7:0] q[$]);
      saw_rd = 0; saw_st = 0;
      host.frame(q);
      repeat (10) @(posedge pclk);
   endtask
   task t_latch;
      st(32'h0000_000F, 32'h0000_0000);
      rdc(12'h0F0, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
      fr('{OP_WRITE_EN}); st(32'h0000_000F, 32'h0000_0008);
      fr('{OP_WRITE_DIS}); st(32'h0000_000F, 32'h0000_0000);
      fr('{OP_STATUS_WRITE, 8'h1C}); apb(1, ADDR_CTRL, 32'h0000_0001);
      fr('{OP_STATUS_WRITE, 8'h1C}); fr('{OP_PAGE_PROGRAM, 8'h00, 8'h01, 8'h00});
      apb(1, ADDR_CTRL, 32'h0000_0000);
      fr('{OP_PARAM_ERASE, 8'h00, 8'h20, 8'h00}); st(32'h0000_000F, 32'h0000_0000);
      chk("effects", 32'h0000_0000, 32'(n_start + n_swr));
   endtask
   task t_swr;
      fr('{OP_WRITE_EN}); fr('{OP_STATUS_WRITE, 8'h1C});
      st(32'h0000_000F, 32'h0000_0008); chk("swr", 32'h0000_0000, 32'(n_swr));
      apb(1, ADDR_CTRL, 32'h0000_0001); fr('{OP_STATUS_WRITE, 8'h1C});
      st(32'h0000_000F, 32'h0000_0000); chk("swr", 32'h0000_0001, 32'(n_swr));
   endtask
   task t_reads;
      apb(1, ADDR_CTRL, 32'h0000_0000); fr('{OP_WRITE_EN});
      fr('{OP_READ_DATA, 8'h00, 8'h00, 8'h10}); chk("read", 32'h1, 32'(saw_rd));
      fr('{OP_FAST_READ, 8'h12, 8'h34, 8'h56}); chk("nodummy", 32'h0, 32'(saw_rd));
      fr('{OP_FAST_READ, 8'h12, 8'h34, 8'h56, 8'hA5}); chk("fast", 32'h1, 32'(saw_rd));
      rdc(ADDR_FAST_ADR, 32'h00FF_FFFF, 32'h0012_3456, "fastaddr");
      fr('{OP_READ_STATUS}); chk("srout", 32'h1, 32'(saw_st));
      fr('{OP_CLEAR_FAIL}); st(32'h0000_000F, 32'h0000_0008);
   endtask
   task t_write(input logic [7:0] op, input logic [31:0] prot, open);
      apb(1, ADDR_CTRL, prot); fr('{op, 8'h00, 8'h20, 8'h00, 8'h55});
      st(32'h0000_000F, 32'h0000_0008); chk("start", 32'h0, 32'(n_start));
      apb(1, ADDR_CTRL, open); fr('{op, 8'h00, 8'h20, 8'h00, 8'h55});
      st(32'h0000_0003, 32'h0000_0001); chk("start", 32'h1, 32'(n_start));
      fr('{OP_WRITE_DIS}); fr('{OP_PAGE_PROGRAM, 8'h00, 8'h00, 8'h00});
      fr('{OP_READ_DATA, 8'h00, 8'h00, 8'h00}); chk("busyread", 32'h0, 32'(saw_rd));
      fr('{OP_READ_STATUS}); chk("busysr", 32'h1, 32'(saw_st));
      st(32'h0000_0003, 32'h0000_0001); chk("start", 32'h1, 32'(n_start));
      apb(1, ADDR_CTRL, 32'h0000_0010); st(32'h0000_000F, 32'h0000_0000);
      n_start = 0;
      fr('{OP_WRITE_EN});
   endtask
   task t_sleep;
      apb(1, ADDR_CTRL, 32'h0000_0008); st(32'h0000_000F, 32'h0000_000B);
      fr('{OP_WRITE_DIS}); fr('{OP_PAGE_PROGRAM, 8'h00, 8'h00, 8'h00});
      st(32'h0000_000F, 32'h0000_000B); chk("start", 32'h0, 32'(n_start));
      apb(1, ADDR_CTRL, 32'h0000_0000); st(32'h0000_000F, 32'h0000_0008);
   endtask
   task results;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #2ms;
      n_errors++;
      results;
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1;
      t_latch;
      t_swr;
      t_reads;
      t_write(OP_PAGE_PROGRAM, 32'h0000_0002, 32'h0000_0000);
      t_write(OP_PARAM_ERASE, 32'h0000_0006, 32'h0000_0002);
      t_sleep;
      results;
   end
endmodule
